/* inc/hrs_pkg.sv */
// package for the switch hot reset sequencer: register map, fields, states, timing
package hrs_pkg;
    // apb register byte addresses
    localparam logic [7:0] ADDR_SWITCH_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_SMBUS_STATUS = 8'h04;
    localparam logic [7:0] ADDR_BRIDGE_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_SEQ_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_EEPROM_CMD = 8'h10;
    // switch_control_reg fields
    localparam int SW_HOT_RESET_TRIGGER = 0;
    localparam int SW_LINK_DOWN_RESET_DISABLE = 1;
    localparam int SW_HOT_RESET_EEPROM_LOAD_DISABLE = 2;
    localparam int SW_RESET_HALT_FLAG = 3;
    localparam int SW_EEPROM_MODE = 4;
    // smbus_status_reg fields
    localparam int SMB_EEPROM_LOAD_DONE = 0;
    localparam int SMB_ERR_LSB = 8;
    // bridge_control_reg field
    localparam int BR_SECONDARY_BUS_RESET_BIT = 6;
    // reset values
    localparam logic [4:0] SWITCH_CONTROL_RESET = 5'h00;
    localparam logic [7:0] NUM_DOWN_PORTS = 8'h06;
    // timing: core clock 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int TRAIN_ENTRY_MS = 20;
    localparam int RETRY_READY_MS = 100;
    localparam int TRAIN_ENTRY_CYC = (CLK_HZ / 1000) * TRAIN_ENTRY_MS;
    localparam int RETRY_READY_CYC = (CLK_HZ / 1000) * RETRY_READY_MS;
    localparam int RESET_HOLD_CYC = 16;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PROPAGATE = 3'b001,
        ST_LOGIC_RESET = 3'b010,
        ST_TRAIN = 3'b011,
        ST_EEPROM = 3'b100,
        ST_HALT = 3'b101
    } hrs_state_t;
    // eeprom loader request/answer
    typedef struct packed {
        logic start;
    } hrs_ee_req_t;
    typedef struct packed {
        logic done;
        logic error;
        logic [7:0] err_code;
        logic set_halt;
    } hrs_ee_rsp_t;
endpackage : hrs_pkg

/* hw/hrs_sequencer.sv */
// switch hot reset sequencer with apb register slave
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module hrs_sequencer
    import hrs_pkg::*;
#(
    parameter int TRAIN_CYC = TRAIN_ENTRY_CYC,
    parameter int RETRY_CYC = RETRY_READY_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic up_hot_reset_rx,       // pin: hot-reset training sets seen
    input wire logic up_dl_down,            // pin: upstream data link down
    input wire logic [5:0] down_link_up,    // pin: downstream links up
    output logic [5:0] down_hot_reset_tx,   // send hot-reset training sets
    output logic core_reset,                // reset of core logic
    output logic reg_reset,                 // reset of non-sticky fields
    output logic link_train_en,             // link training enable
    output logic stack_quasi_reset,         // stacks answer config with retry
    output logic ee_start,                  // eeprom loader start pulse
    input wire logic ee_done,               // loader finished, same clock
    input wire logic ee_error,              // loader error, same clock
    input wire logic [7:0] ee_err_code,
    input wire logic ee_set_halt,           // halt written from eeprom contents
    input wire logic smb_valid,             // slave smbus register access
    input wire logic smb_write,
    input wire logic [7:0] smb_addr,
    input wire logic [31:0] smb_wdata,
    output logic [31:0] smb_rdata
);
    hrs_state_t state_q, state_d;
    hrs_ee_rsp_t ee_rsp;
    logic hr_s1_q, hr_s2_q, dl_s1_q, dl_s2_q;
    logic [5:0] lu_s1_q, lu_s2_q;
    logic dl_prev_q;
    logic [4:0] switch_control_reg_q;
    logic halt_q, ee_done_q, sbr_q, pend_q, sbr_seq_q;
    logic [7:0] ee_err_q;
    logic [31:0] cnt_q;
    logic [31:0] rdata_mux;

    assign ee_rsp = '{done: ee_done, error: ee_error, err_code: ee_err_code,
                      set_halt: ee_set_halt};

    // two-stage synchronisers for the link status pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hr_s1_q <= 1'b0;
            hr_s2_q <= 1'b0;
            dl_s1_q <= 1'b0;
            dl_s2_q <= 1'b0;
            lu_s1_q <= 6'h00;
            lu_s2_q <= 6'h00;
            dl_prev_q <= 1'b0;
        end else begin
            hr_s1_q <= up_hot_reset_rx;
            hr_s2_q <= hr_s1_q;
            dl_s1_q <= up_dl_down;
            dl_s2_q <= dl_s1_q;
            lu_s1_q <= down_link_up;
            lu_s2_q <= lu_s1_q;
            dl_prev_q <= dl_s2_q;
        end
    end

    // apb decode, writes take effect in the access cycle
    wire apb_wr = psel && penable && pwrite;
    wire sel_sw = (paddr == ADDR_SWITCH_CONTROL);
    wire sel_smb = (paddr == ADDR_SMBUS_STATUS);
    wire sel_br = (paddr == ADDR_BRIDGE_CONTROL);
    wire sel_st = (paddr == ADDR_SEQ_STATUS);
    wire sel_ok = sel_sw || sel_smb || sel_br || sel_st;
    wire wr_sw = apb_wr && sel_sw && !core_reset;
    wire wr_br = apb_wr && sel_br && !core_reset;
    wire sw_trig = wr_sw && pwdata[SW_HOT_RESET_TRIGGER];
    wire sbr_trig = wr_br && pwdata[BR_SECONDARY_BUS_RESET_BIT]
                    && !sbr_q;
    // smbus access: registers under reset read zero, a halt clear write still takes effect
    wire smb_live = !core_reset;
    wire smb_wr_sw = smb_valid && smb_write && (smb_addr == ADDR_SWITCH_CONTROL);
    wire smb_clr_halt = smb_wr_sw && !smb_wdata[SW_RESET_HALT_FLAG];

    // trigger sources; the disable bit masks only link-down
    wire hr_rx = hr_s2_q;
    wire dl_edge = dl_s2_q && !dl_prev_q
                   && !switch_control_reg_q[SW_LINK_DOWN_RESET_DISABLE];
    wire hw_trig = hr_rx || dl_edge;
    // software trigger waits one cycle so the write completion goes first
    wire trig = hw_trig || pend_q;
    wire cnt_done = (cnt_q == 32'h0);
    wire ee_need = switch_control_reg_q[SW_EEPROM_MODE]
                   && !switch_control_reg_q[SW_HOT_RESET_EEPROM_LOAD_DISABLE];

    // control and status registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_control_reg_q <= SWITCH_CONTROL_RESET;
            halt_q <= 1'b0;
            ee_done_q <= 1'b0;
            ee_err_q <= 8'h00;
            sbr_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            pend_q <= sw_trig;
            if (wr_sw) begin
                // trigger bit is self clearing, never stored
                // each field at its own bit; halt lives in halt_q
                switch_control_reg_q <= {pwdata[SW_EEPROM_MODE], 1'b0, pwdata[SW_HOT_RESET_EEPROM_LOAD_DISABLE],
                            pwdata[SW_LINK_DOWN_RESET_DISABLE], 1'b0};
            end
            if (wr_br) begin
                sbr_q <= pwdata[BR_SECONDARY_BUS_RESET_BIT];
            end else if (reg_reset) begin
                sbr_q <= 1'b0;
            end
            // halt set by eeprom wins over an smbus clear in the same cycle
            if (state_q == ST_EEPROM && (ee_rsp.error || ee_rsp.set_halt)) begin
                halt_q <= 1'b1;
            end else if (smb_clr_halt) begin
                halt_q <= 1'b0;
            end
            if (state_q == ST_EEPROM && (ee_rsp.done || ee_rsp.error)) begin
                ee_done_q <= 1'b1;
            end else if (state_q == ST_PROPAGATE) begin
                ee_done_q <= 1'b0;
            end
            if (state_q == ST_EEPROM && ee_rsp.error) begin
                ee_err_q <= ee_rsp.err_code;
            end
        end
    end

    // sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (trig || sbr_trig) begin
                    state_d = ST_PROPAGATE;
                end
            end
            ST_PROPAGATE: begin
                if (cnt_done) begin
                    state_d = sbr_seq_q ? ST_IDLE : ST_LOGIC_RESET;
                end
            end
            ST_LOGIC_RESET: begin
                if (cnt_done) begin
                    state_d = ST_TRAIN;
                end
            end
            ST_TRAIN: begin
                if (cnt_done) begin
                    state_d = ee_need ? ST_EEPROM : ST_IDLE;
                end
            end
            ST_EEPROM: begin
                if (ee_rsp.error || ee_rsp.set_halt) begin
                    state_d = ST_HALT;
                end else if (ee_rsp.done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (!halt_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // a fresh trigger mid sequence restarts from propagation
        if (state_q != ST_IDLE && state_q != ST_HALT && trig) begin
            state_d = ST_PROPAGATE;
        end
    end

    // state, phase counter and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            sbr_seq_q <= 1'b0;
            cnt_q <= 32'h0;
            down_hot_reset_tx <= 6'h00;
            core_reset <= 1'b0;
            reg_reset <= 1'b0;
            link_train_en <= 1'b1;
            stack_quasi_reset <= 1'b0;
            ee_start <= 1'b0;
        end else begin
            state_q <= state_d;
            // a pass started by the secondary bus reset alone skips the logic reset
            if (state_d == ST_PROPAGATE && (state_q == ST_IDLE || trig)) begin
                sbr_seq_q <= !trig;
            end
            if (state_d != state_q || (state_q == ST_PROPAGATE && trig)) begin
                cnt_q <= (state_d == ST_TRAIN) ? 32'(RETRY_CYC - 1) : 32'(RESET_HOLD_CYC - 1);
            end else if (!cnt_done) begin
                cnt_q <= cnt_q - 32'h1;
            end
            down_hot_reset_tx <= (state_d == ST_PROPAGATE) ? lu_s2_q : 6'h00;
            core_reset <= (state_d == ST_LOGIC_RESET) || (state_d == ST_HALT);
            reg_reset <= (state_d == ST_LOGIC_RESET);
            // training starts at once, well inside the entry limit
            link_train_en <= (state_d != ST_PROPAGATE) && (state_d != ST_LOGIC_RESET);
            stack_quasi_reset <= (state_d == ST_TRAIN) || (state_d == ST_EEPROM)
                                 || (state_d == ST_HALT);
            ee_start <= (state_d == ST_EEPROM) && (state_q != ST_EEPROM);
        end
    end

    // read data select; unmapped addresses read zero with an error
    wire [31:0] rd_sw = {27'h0, switch_control_reg_q[4], halt_q, switch_control_reg_q[2:1], 1'b0};
    wire [31:0] rd_smb = {16'h0, ee_err_q, 7'h0, ee_done_q};
    wire [31:0] rd_br = {25'h0, sbr_q, 6'h0};
    wire [31:0] rd_st = {20'h0, 1'b0, state_q, 8'h0 | {2'h0, lu_s2_q}};
    assign rdata_mux = sel_sw ? rd_sw : sel_smb ? rd_smb : sel_br ? rd_br
                       : sel_st ? rd_st : 32'h0;

    // apb answer one cycle after setup, smbus read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            smb_rdata <= 32'h0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !sel_ok;
            prdata <= (psel && !penable && !pwrite && !core_reset) ? rdata_mux : 32'h0;
            smb_rdata <= (smb_valid && !smb_write && smb_live) ? rd_smb : 32'h0;
        end
    end
    // TRAIN_CYC bounds the training entry; entry here is immediate
    wire unused_train = (TRAIN_CYC == 0) ^ pslverr ^ ee_rsp.done;
endmodule : hrs_sequencer
`default_nettype wire

/* tb/hrs_sequencer_properties.sv */
// port checker for the hot reset sequencer
`timescale 1ns/100ps
`default_nettype none
module hrs_seq_properties
    import hrs_pkg::*;
#(
    parameter int RETRY_CYC = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [5:0] down_link_up,
    input wire logic [5:0] down_hot_reset_tx,
    input wire logic core_reset,
    input wire logic reg_reset,
    input wire logic link_train_en,
    input wire logic stack_quasi_reset,
    input wire logic ee_start,
    input wire logic ee_error,
    input wire logic smb_valid,
    input wire logic smb_write,
    input wire logic [31:0] smb_rdata
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // trigger write accepted while the sequencer is idle
    wire sw_hit = psel && penable && pready && pwrite && paddr == ADDR_SWITCH_CONTROL
        && pwdata[0] && !core_reset && !stack_quasi_reset && down_hot_reset_tx == 6'h00;
    a_write_first: assert property (sw_hit |=> down_hot_reset_tx == 6'h00
        ##[1:3] down_hot_reset_tx == down_link_up) else $error("trigger write order wrong");
    a_tx_up_only: assert property (down_hot_reset_tx != 6'h00
        |-> (down_hot_reset_tx & ~down_link_up) == 6'h00) else $error("tx on a down link");
    a_reg_in_core: assert property (reg_reset |-> core_reset)
        else $error("register reset without core reset");
    a_no_train: assert property (reg_reset |-> !link_train_en)
        else $error("training during logic reset");
    a_quasi_next: assert property ($fell(reg_reset) && link_train_en |-> stack_quasi_reset)
        else $error("no quasi reset after logic reset");
    a_train_quasi: assert property (stack_quasi_reset && !core_reset |-> link_train_en)
        else $error("links not training in quasi reset");
    a_start_pulse: assert property (ee_start |=> !ee_start)
        else $error("load start longer than a cycle");
    a_error_halts: assert property (ee_error |-> ##[1:3] core_reset && stack_quasi_reset)
        else $error("load error did not halt");
    a_smb_zero: assert property (smb_valid && !smb_write && core_reset
        |=> smb_rdata == 32'h0) else $error("smbus read not zero in reset");
    a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule : hrs_seq_properties
bind hrs_sequencer hrs_seq_properties #(.RETRY_CYC(RETRY_CYC)) i_prop (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .down_link_up(down_link_up),
    .down_hot_reset_tx(down_hot_reset_tx), .core_reset(core_reset), .reg_reset(reg_reset),
    .link_train_en(link_train_en), .stack_quasi_reset(stack_quasi_reset),
    .ee_start(ee_start), .ee_error(ee_error), .smb_valid(smb_valid), .smb_write(smb_write),
    .smb_rdata(smb_rdata)
);
`default_nettype wire

/* tb/hrs_ee_model.sv */
// eeprom loader model answering load requests
`timescale 1ns/100ps
`default_nettype none
module hrs_ee_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ee_start,
    input wire logic ee_fail,
    input wire logic [7:0] ee_dly,
    output logic ee_done,
    output logic ee_error,
    output logic [7:0] ee_err_code,
    output logic ee_set_halt
);
    logic [7:0] cnt_q;
    // load runs for ee_dly cycles after the start pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
        end else if (ee_start) begin
            cnt_q <= ee_dly;
        end else if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
        end
    end
    // done pulse at the end, error and code 5a only when told to fail, code ff otherwise
    assign ee_done = cnt_q == 8'h01;
    assign ee_error = ee_done && ee_fail;
    assign ee_err_code = ee_error ? 8'h5a : 8'hff;
    assign ee_set_halt = 1'b0; // halt comes from load errors only
endmodule : hrs_ee_model
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench of the hot reset sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import hrs_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, smb_addr = 8'h00, ee_dly = 8'h04, ee_err_code;
    logic [31:0] pwdata = 32'h0, smb_wdata = 32'h0, prdata, smb_rdata, rd;
    logic up_hot_reset_rx = 1'b0, up_dl_down = 1'b0, smb_valid = 1'b0, smb_write = 1'b0;
    logic ee_fail = 1'b0, pready, pslverr, core_reset, reg_reset, link_train_en, err;
    logic stack_quasi_reset, ee_start, ee_done, ee_error, ee_set_halt;
    logic [5:0] down_link_up = 6'h3f, down_hot_reset_tx, links = 6'h3f;
    int mismatches = 0, checks = 0, n;
    hrs_sequencer #(.RETRY_CYC(50)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .up_hot_reset_rx(up_hot_reset_rx), .up_dl_down(up_dl_down),
        .down_link_up(down_link_up), .down_hot_reset_tx(down_hot_reset_tx),
        .core_reset(core_reset), .reg_reset(reg_reset), .link_train_en(link_train_en),
        .stack_quasi_reset(stack_quasi_reset), .ee_start(ee_start), .ee_done(ee_done),
        .ee_error(ee_error), .ee_err_code(ee_err_code), .ee_set_halt(ee_set_halt),
        .smb_valid(smb_valid), .smb_write(smb_write), .smb_addr(smb_addr),
        .smb_wdata(smb_wdata), .smb_rdata(smb_rdata)
    );
    hrs_ee_model i_ee (
        .pclk(pclk), .presetn(presetn), .ee_start(ee_start), .ee_fail(ee_fail),
        .ee_dly(ee_dly), .ee_done(ee_done), .ee_error(ee_error), .ee_err_code(ee_err_code),
        .ee_set_halt(ee_set_halt)
    );
    // clock and watchdog
    initial forever #25 pclk = ~pclk;
    initial begin
        #(20000 * 50);
        mismatches++;
        results;
    end
    function automatic logic [31:0] exp_sts(input logic [7:0] code);
        return {16'h0000, code, 8'h01};
    endfunction : exp_sts
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold the request until pready is seen high at a rising edge
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic smb(input logic w, input logic [31:0] d);
        @(posedge pclk);
        smb_valid <= 1'b1;
        smb_write <= w;
        smb_addr <= ADDR_SWITCH_CONTROL;
        smb_wdata <= d;
        @(posedge pclk);
        smb_valid <= 1'b0;
    endtask : smb
    task automatic wtx(input string what);
        for (n = 0; n < 20 && down_hot_reset_tx === 6'h00; n++) @(posedge pclk);
        chk(what, 32'(down_hot_reset_tx), 32'(links));
    endtask : wtx
    task automatic idle;
        // drop the trigger pins first, then wait out every phase incl. propagation
        up_hot_reset_rx <= 1'b0;
        up_dl_down <= 1'b0;
        repeat (4) @(posedge pclk);
        for (n = 0; n < 400 && (core_reset | stack_quasi_reset | !link_train_en) !== 1'b0; n++) begin
            @(posedge pclk);
        end
        chk("sequence end", {31'h0, core_reset | stack_quasi_reset | !link_train_en}, 32'h0);
        $display("test step done");
    endtask : idle
    task automatic results;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        n = $urandom(32'h9ccc1096);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_SWITCH_CONTROL, 32'h0);
        chk("switch control", rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        for (int i = 0; i < 3; i++) begin
            links = 6'($urandom) | 6'h01;
            down_link_up <= links;
            apb(1'b1, ADDR_SWITCH_CONTROL, 32'h1);
            wtx("sw trigger");
            idle;
        end
        apb(1'b1, ADDR_SWITCH_CONTROL, 32'h2);
        up_dl_down <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("masked link down", {26'h0, down_hot_reset_tx}, 32'h0);
        up_hot_reset_rx <= 1'b1;
        wtx("rx trigger");
        idle;
        apb(1'b1, ADDR_SWITCH_CONTROL, 32'h0);
        up_dl_down <= 1'b1;
        wtx("link down");
        idle;
        apb(1'b1, ADDR_SWITCH_CONTROL, 32'h1);
        for (n = 0; n < 100 && stack_quasi_reset !== 1'b1; n++) @(posedge pclk);
        up_hot_reset_rx <= 1'b1;
        wtx("restart");
        idle;
        apb(1'b1, ADDR_BRIDGE_CONTROL, 32'h1 << BR_SECONDARY_BUS_RESET_BIT);
        wtx("secondary reset");
        idle;
        apb(1'b1, ADDR_SWITCH_CONTROL, 32'h15);
        for (n = 0; n < 200 && ee_start !== 1'b1; n++) @(posedge pclk);
        chk("load disabled", 32'(n), 32'd200);
        idle;
        for (int f = 0; f < 2; f++) begin
            ee_fail <= f[0];
            ee_dly <= 8'($urandom_range(40, 1));
            apb(1'b1, ADDR_SWITCH_CONTROL, 32'h11);
            for (n = 0; n < 300 && ee_start !== 1'b1; n++) @(posedge pclk);
            chk("load start", {31'h0, ee_start}, 32'h1);
            repeat (60) @(posedge pclk);
            chk("halt", {31'h0, core_reset}, 32'(f));
            smb(1'b0, 32'h0);
            @(posedge pclk);
            chk("smbus read", smb_rdata, f ? 32'h0 : 32'h1);
            smb(1'b1, 32'h0);
            idle;
            chk("halt cleared", {31'h0, core_reset}, 32'h0);
            apb(1'b0, ADDR_SMBUS_STATUS, 32'h0);
            chk("status", rd & (f ? 32'hff01 : 32'h1), f ? exp_sts(8'h5a) : 32'h1);
        end
        results;
    end
endmodule : tb_top
`default_nettype wire
